// *** dv/epsm_periph_model.sv ***
`timescale 1ns/100ps
module epsm_periph_model
  import epsm_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic srcHold,
  output logic [5:0] cardZeroOut,
  output logic [5:0] cardZeroOe,
  output logic [3:0] audioZeroOut,
  output logic [3:0] audioZeroOe,
  output logic [5:0] gpLowOut,
  output logic [5:0] gpLowOe,
  output logic [5:0] cardOneOut,
  output logic [5:0] cardOneOe,
  output logic [3:0] audioOneOut,
  output logic [3:0] audioOneOe,
  output logic [5:0] gpMidOut,
  output logic [5:0] gpMidOe,
  output logic [5:0] emAddrOut,
  output logic [5:0] emAddrOe,
  output logic [5:0] gpHighOut,
  output logic [5:0] gpHighOe,
  input wire logic [5:0] port0PadOut,
  input wire logic [5:0] port0PadOe,
  output logic [5:0] port0PadIn,
  input wire logic [5:0] port1PadOut,
  input wire logic [5:0] port1PadOe,
  output logic [5:0] port1PadIn,
  input wire logic [5:0] addrPadOut,
  input wire logic [5:0] addrPadOe,
  output logic [5:0] addrPadIn
);
  logic [5:0] cnt_q;

  // ******************
  // Peripheral sources
  // ******************
  // Sources move every cycle that srcHold is low and differ by fixed masks, so a wrong mux leg shows on the bits where the masks differ
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 6'h00;
    end else if (!srcHold) begin
      // Peripheral clocks stand still while software rewrites the routing
      cnt_q <= cnt_q + 6'h01;
    end
  end
  assign cardZeroOut = cnt_q ^ 6'h01;
  assign cardZeroOe = cnt_q ^ 6'h02;
  assign audioZeroOut = cnt_q[3:0] ^ 4'h3;
  assign audioZeroOe = cnt_q[3:0] ^ 4'h4;
  assign gpLowOut = cnt_q ^ 6'h05;
  assign gpLowOe = cnt_q ^ 6'h06;
  assign cardOneOut = cnt_q ^ 6'h07;
  assign cardOneOe = cnt_q ^ 6'h08;
  assign audioOneOut = cnt_q[3:0] ^ 4'h9;
  assign audioOneOe = cnt_q[3:0] ^ 4'hA;
  assign gpMidOut = cnt_q ^ 6'h0B;
  assign gpMidOe = cnt_q ^ 6'h0C;
  assign emAddrOut = cnt_q ^ 6'h0D;
  assign emAddrOe = cnt_q ^ 6'h0E;
  assign gpHighOut = cnt_q ^ 6'h0F;
  assign gpHighOe = cnt_q ^ 6'h10;

  // ******************
  // Shared pins
  // ******************
  // Undriven pins show a pattern that moves with the sources and holds only while srcHold is high
  assign port0PadIn = (port0PadOut & port0PadOe) | ((~cnt_q ^ 6'h11) & ~port0PadOe);
  assign port1PadIn = (port1PadOut & port1PadOe) | ((~cnt_q ^ 6'h12) & ~port1PadOe);
  assign addrPadIn = (addrPadOut & addrPadOe) | ((~cnt_q ^ 6'h13) & ~addrPadOe);
endmodule // epsm_periph_model

// *** dv/epsm_pin_select_bench.sv ***
`timescale 1ns/100ps
module epsm_pin_select_bench
  import epsm_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic ioWrEn = 1'b0;
  logic ioRdEn = 1'b0;
  logic [15:0] ioAddr = EPSM_SEL_ADDR;
  logic [15:0] ioWrData = 16'h0000;
  logic [15:0] ioRdData;
  logic [2:0] parallelPortMode;
  logic [5:0] cardZeroOut, cardZeroOe, cardZeroIn, gpLowOut, gpLowOe, gpLowIn;
  logic [3:0] audioZeroOut, audioZeroOe, audioZeroIn, audioOneOut, audioOneOe, audioOneIn;
  logic [5:0] cardOneOut, cardOneOe, cardOneIn, gpMidOut, gpMidOe, gpMidIn;
  logic [5:0] port0PadOut, port0PadOe, port0PadIn, port1PadOut, port1PadOe, port1PadIn;
  logic [5:0] emAddrOut, emAddrOe, gpHighOut, gpHighOe, gpHighIn;
  logic [5:0] addrPadOut, addrPadOe, addrPadIn;
  int mismatches = 0;
  int comparisons = 0;

  always #25 clk = ~clk;

  epsm_pin_select dut_u (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .ioAddr(ioAddr),
    .ioWrEn(ioWrEn),
    .ioRdEn(ioRdEn),
    .ioWrData(ioWrData),
    .ioRdData(ioRdData),
    .parallelPortMode(parallelPortMode),
    .cardZeroOut(cardZeroOut),
    .cardZeroOe(cardZeroOe),
    .cardZeroIn(cardZeroIn),
    .audioZeroOut(audioZeroOut),
    .audioZeroOe(audioZeroOe),
    .audioZeroIn(audioZeroIn),
    .gpLowOut(gpLowOut),
    .gpLowOe(gpLowOe),
    .gpLowIn(gpLowIn),
    .port0PadOut(port0PadOut),
    .port0PadOe(port0PadOe),
    .port0PadIn(port0PadIn),
    .cardOneOut(cardOneOut),
    .cardOneOe(cardOneOe),
    .cardOneIn(cardOneIn),
    .audioOneOut(audioOneOut),
    .audioOneOe(audioOneOe),
    .audioOneIn(audioOneIn),
    .gpMidOut(gpMidOut),
    .gpMidOe(gpMidOe),
    .gpMidIn(gpMidIn),
    .port1PadOut(port1PadOut),
    .port1PadOe(port1PadOe),
    .port1PadIn(port1PadIn),
    .emAddrOut(emAddrOut),
    .emAddrOe(emAddrOe),
    .gpHighOut(gpHighOut),
    .gpHighOe(gpHighOe),
    .gpHighIn(gpHighIn),
    .addrPadOut(addrPadOut),
    .addrPadOe(addrPadOe),
    .addrPadIn(addrPadIn)
  );

  // Sources freeze during a write strobe, standing in for gated peripheral clocks
  epsm_periph_model model_u (
    .clk(clk),
    .arst_n(arst_n),
    .srcHold(ioWrEn),
    .cardZeroOut(cardZeroOut),
    .cardZeroOe(cardZeroOe),
    .audioZeroOut(audioZeroOut),
    .audioZeroOe(audioZeroOe),
    .gpLowOut(gpLowOut),
    .gpLowOe(gpLowOe),
    .cardOneOut(cardOneOut),
    .cardOneOe(cardOneOe),
    .audioOneOut(audioOneOut),
    .audioOneOe(audioOneOe),
    .gpMidOut(gpMidOut),
    .gpMidOe(gpMidOe),
    .emAddrOut(emAddrOut),
    .emAddrOe(emAddrOe),
    .gpHighOut(gpHighOut),
    .gpHighOe(gpHighOe),
    .port0PadOut(port0PadOut),
    .port0PadOe(port0PadOe),
    .port0PadIn(port0PadIn),
    .port1PadOut(port1PadOut),
    .port1PadOe(port1PadOe),
    .port1PadIn(port1PadIn),
    .addrPadOut(addrPadOut),
    .addrPadOe(addrPadOe),
    .addrPadIn(addrPadIn)
  );

  // ******************
  // Shared tasks
  // ******************
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // An idle cycle follows each access so a strobe is never dropped and raised in one step
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    ioAddr = a;
    ioWrData = d;
    ioWrEn = 1'b1;
    @(posedge clk);
    #2;
    ioWrEn = 1'b0;
    @(posedge clk);
    #2;
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] v);
    ioAddr = a;
    ioRdEn = 1'b1;
    @(posedge clk);
    #2;
    ioRdEn = 1'b0;
    v = ioRdData;
    @(posedge clk);
    #2;
  endtask

  function automatic logic [5:0] pick(logic [1:0] m, logic [5:0] c, logic [3:0] u, logic [5:0] g);
    return m == 2'h0 ? c : m == 2'h1 ? {g[5:4], u} : m == 2'h2 ? g : 6'h00;
  endfunction

  function automatic logic [5:0] gpin(logic [1:0] m, logic [5:0] p);
    return m == 2'h2 ? p : m == 2'h1 ? {p[5:4], 4'h0} : 6'h00;
  endfunction

  task automatic check_pins(input logic [15:0] r);
    logic [1:0] m0, m1;
    logic [5:0] a;
    m0 = r[9:8];
    m1 = r[11:10];
    a = r[5:0];
    chk("pad0 out", port0PadOut, pick(m0, cardZeroOut, audioZeroOut, gpLowOut));
    chk("pad0 oe", port0PadOe, pick(m0, cardZeroOe, audioZeroOe, gpLowOe));
    chk("card0 in", cardZeroIn, m0 == 2'h0 ? port0PadIn : 6'h00);
    chk("aud0 in", audioZeroIn, m0 == 2'h1 ? port0PadIn[3:0] : 4'h0);
    chk("gp0 in", gpLowIn, gpin(m0, port0PadIn));
    chk("pad1 out", port1PadOut, pick(m1, cardOneOut, audioOneOut, gpMidOut));
    chk("pad1 oe", port1PadOe, pick(m1, cardOneOe, audioOneOe, gpMidOe));
    chk("card1 in", cardOneIn, m1 == 2'h0 ? port1PadIn : 6'h00);
    chk("aud1 in", audioOneIn, m1 == 2'h1 ? port1PadIn[3:0] : 4'h0);
    chk("gp1 in", gpMidIn, gpin(m1, port1PadIn));
    chk("addr out", addrPadOut, (a & gpHighOut) | (~a & emAddrOut));
    chk("addr oe", addrPadOe, (a & gpHighOe) | (~a & emAddrOe));
    chk("gp hi in", gpHighIn, a & addrPadIn);
    chk("pp mode", parallelPortMode, r[14:12]);
  endtask

  // ******************
  // Scenarios
  // ******************
  task automatic t_reset();
    logic [15:0] v;
    rd(EPSM_SEL_ADDR, v);
    chk("reset value", v, EPSM_SEL_RESET);
    check_pins(EPSM_SEL_RESET);
  endtask

  // Both ports step through every code, never sharing one, so swapped fields show
  task automatic t_ports();
    logic [15:0] v, r;
    for (int m = 0; m < 4; m++) begin
      r = {4'h0, 2'(m) ^ 2'h1, 2'(m), 8'h00};
      wr(EPSM_SEL_ADDR, r);
      rd(EPSM_SEL_ADDR, v);
      chk("mode fields", v, r);
      check_pins(r);
    end
  endtask

  task automatic t_addr();
    logic [15:0] r;
    for (int i = 0; i < 6; i++) begin
      r = 16'h2000 | (16'h0001 << i);
      wr(EPSM_SEL_ADDR, r);
      check_pins(r);
    end
  endtask

  task automatic t_resv();
    logic [15:0] v;
    wr(EPSM_SEL_ADDR, 16'hFFFF);
    rd(EPSM_SEL_ADDR, v);
    chk("reserved bits", v, 16'h7F3F);
    wr(16'h1C01, 16'h0000);
    ce = 1'b0;
    wr(EPSM_SEL_ADDR, 16'h0000);
    ce = 1'b1;
    rd(EPSM_SEL_ADDR, v);
    chk("ignored writes", v, 16'h7F3F);
    rd(16'h1C01, v);
    chk("unmapped read", v, 16'h0000);
  endtask

  task automatic t_timing();
    ioAddr = EPSM_SEL_ADDR;
    ioWrData = 16'h0A00;
    ioWrEn = 1'b1;
    #10;
    check_pins(16'h7F3F);
    @(posedge clk);
    #2;
    ioWrEn = 1'b0;
    check_pins(16'h0A00);
    @(posedge clk);
    #2;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    #2;
    arst_n = 1'b1;
    t_reset();
    t_ports();
    t_addr();
    t_resv();
    t_timing();
    arst_n = 1'b0;
    @(posedge clk);
    #2;
    arst_n = 1'b1;
    t_reset();
    close_out();
  end
endmodule // epsm_pin_select_bench

// *** include/epsm_pkg.sv ***
package epsm_pkg;

  // ********************************************************
  // Register location and layout
  // ********************************************************
  localparam logic [15:0] EPSM_SEL_ADDR = 16'h1C00;
  localparam int EPSM_DATA_W = 16;
  localparam logic [15:0] EPSM_SEL_RESET = 16'h0000;

  localparam int EPSM_PP_LSB = 12;
  localparam int EPSM_PP_MSB = 14;
  localparam int EPSM_SP1_LSB = 10;
  localparam int EPSM_SP1_MSB = 11;
  localparam int EPSM_SP0_LSB = 8;
  localparam int EPSM_SP0_MSB = 9;
  localparam int EPSM_ADDR_LSB = 0;
  localparam int EPSM_ADDR_MSB = 5;

  localparam logic [2:0] EPSM_PP_RESET = 3'h0;
  localparam logic [1:0] EPSM_SP_RESET = 2'h0;
  localparam logic [5:0] EPSM_ADDR_RESET = 6'h00;

  // ********************************************************
  // Pin counts and serial port mode codes
  // ********************************************************
  localparam int EPSM_SP_PINS = 6;
  localparam int EPSM_AUD_PINS = 4;
  localparam int EPSM_ADDR_PINS = 6;

  localparam logic [1:0] EPSM_SP_MODE_CARD = 2'h0;
  localparam logic [1:0] EPSM_SP_MODE_AUDIO = 2'h1;
  localparam logic [1:0] EPSM_SP_MODE_GPIO = 2'h2;
  localparam logic [1:0] EPSM_SP_MODE_RESV = 2'h3;

endpackage

// *** rtl/epsm_addr_mux.sv ***
`timescale 1ns/100ps
module epsm_addr_mux
  import epsm_pkg::*;
(
  input wire logic [5:0] pinSel,
  input wire logic [5:0] emAddrOut,
  input wire logic [5:0] emAddrOe,
  input wire logic [5:0] gpOut,
  input wire logic [5:0] gpOe,
  output logic [5:0] gpIn,
  output logic [5:0] padOut,
  output logic [5:0] padOe,
  input wire logic [5:0] padIn
);

  // ********************************************************
  // One select bit per shared address pin
  // ********************************************************
  genvar i;
  generate
    for (i = 0; i < EPSM_ADDR_PINS; i++) begin : g_pin
      assign padOut[i] = pinSel[i] ? gpOut[i] : emAddrOut[i];
      assign padOe[i] = pinSel[i] ? gpOe[i] : emAddrOe[i];
      // Input seen by the general-purpose block is quiet while the pin is an address
      assign gpIn[i] = pinSel[i] & padIn[i];
    end
  endgenerate

endmodule // epsm_addr_mux

// *** rtl/epsm_pin_select.sv ***
`timescale 1ns/100ps
// Notes on behaviour
// - Bits 11:10 hold the second serial port mode.
// - Second port code 01: audio unit one plus general lines 11:10.
// - Second port code 10: general lines 11 down to 6.
// - Bits 9:8 hold the first serial port mode.
// - First port code 00: all six memory card unit zero signals.
// - First port code 01: audio unit zero plus general lines 5:4.
// - First port code 10: general lines 5 down to 0.
// - Bits 7 and 6 read zero and ignore writes.
// - Bit 5 picks address line 20 or general line 26.
// - Bit 3 picks address line 18 or general line 24.
// - Bit 2 picks address line 17 or general line 23.
// - Bit 1 picks address line 16 or general line 22.
// - Bit 0 picks address line 15 or general line 21.
// - New routing takes effect the clock cycle after the write.
// - Bits 14:12 are a read/write parallel port mode, reset 000.
module epsm_pin_select
  import epsm_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [15:0] ioAddr,
  input wire logic ioWrEn,
  input wire logic ioRdEn,
  input wire logic [15:0] ioWrData,
  output logic [15:0] ioRdData,
  output logic [2:0] parallelPortMode,
  input wire logic [5:0] cardZeroOut,
  input wire logic [5:0] cardZeroOe,
  output logic [5:0] cardZeroIn,
  input wire logic [3:0] audioZeroOut,
  input wire logic [3:0] audioZeroOe,
  output logic [3:0] audioZeroIn,
  input wire logic [5:0] gpLowOut,
  input wire logic [5:0] gpLowOe,
  output logic [5:0] gpLowIn,
  output logic [5:0] port0PadOut,
  output logic [5:0] port0PadOe,
  input wire logic [5:0] port0PadIn,
  input wire logic [5:0] cardOneOut,
  input wire logic [5:0] cardOneOe,
  output logic [5:0] cardOneIn,
  input wire logic [3:0] audioOneOut,
  input wire logic [3:0] audioOneOe,
  output logic [3:0] audioOneIn,
  input wire logic [5:0] gpMidOut,
  input wire logic [5:0] gpMidOe,
  output logic [5:0] gpMidIn,
  output logic [5:0] port1PadOut,
  output logic [5:0] port1PadOe,
  input wire logic [5:0] port1PadIn,
  input wire logic [5:0] emAddrOut,
  input wire logic [5:0] emAddrOe,
  input wire logic [5:0] gpHighOut,
  input wire logic [5:0] gpHighOe,
  output logic [5:0] gpHighIn,
  output logic [5:0] addrPadOut,
  output logic [5:0] addrPadOe,
  input wire logic [5:0] addrPadIn
);

  // ********************************************************
  // Register decode
  // ********************************************************
  logic [2:0] parallel_port_mode_q;
  logic [1:0] second_serial_port_mode_q;
  logic [1:0] first_serial_port_mode_q;
  logic [5:0] addrSel_q;
  logic [15:0] rdData_q;

  wire addrHit = (ioAddr == EPSM_SEL_ADDR);
  wire wrHit = ce && ioWrEn && addrHit;
  wire rdStrobe = ce && ioRdEn;
  // Only the defined fields are stored, so reserved bits cannot be set
  wire [2:0] parallel_port_mode_d = ioWrData[EPSM_PP_MSB:EPSM_PP_LSB];
  wire [1:0] second_serial_port_mode_d = ioWrData[EPSM_SP1_MSB:EPSM_SP1_LSB];
  wire [1:0] first_serial_port_mode_d = ioWrData[EPSM_SP0_MSB:EPSM_SP0_LSB];
  wire [5:0] addrSel_d = ioWrData[EPSM_ADDR_MSB:EPSM_ADDR_LSB];
  wire [15:0] selImage = {1'b0, parallel_port_mode_q, second_serial_port_mode_q, first_serial_port_mode_q, 2'b00, addrSel_q};
  // Unmapped addresses read as zero
  wire [15:0] rdData_d = addrHit ? selImage : EPSM_SEL_RESET;

  // ********************************************************
  // Selection register
  // ********************************************************
  // Routing follows the stored fields, so a write lands on the next edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      parallel_port_mode_q <= EPSM_PP_RESET;
      second_serial_port_mode_q <= EPSM_SP_RESET;
      first_serial_port_mode_q <= EPSM_SP_RESET;
      addrSel_q <= EPSM_ADDR_RESET;
    end else if (wrHit) begin
      parallel_port_mode_q <= parallel_port_mode_d;
      second_serial_port_mode_q <= second_serial_port_mode_d;
      first_serial_port_mode_q <= first_serial_port_mode_d;
      addrSel_q <= addrSel_d;
    end
  end

  // Read data is registered: valid the cycle after the read strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData_q <= EPSM_SEL_RESET;
    end else if (rdStrobe) begin
      rdData_q <= rdData_d;
    end
  end

  assign ioRdData = rdData_q;
  assign parallelPortMode = parallel_port_mode_q;

  // ********************************************************
  // Pin multiplexers
  // ********************************************************
  // Peripheral clocks are expected gated during a change, so no glitch guard here
  epsm_serial_mux u_port0 (
    .modeSel(first_serial_port_mode_q),
    .cardOut(cardZeroOut),
    .cardOe(cardZeroOe),
    .cardIn(cardZeroIn),
    .audOut(audioZeroOut),
    .audOe(audioZeroOe),
    .audIn(audioZeroIn),
    .gpOut(gpLowOut),
    .gpOe(gpLowOe),
    .gpIn(gpLowIn),
    .padOut(port0PadOut),
    .padOe(port0PadOe),
    .padIn(port0PadIn)
  );

  epsm_serial_mux u_port1 (
    .modeSel(second_serial_port_mode_q),
    .cardOut(cardOneOut),
    .cardOe(cardOneOe),
    .cardIn(cardOneIn),
    .audOut(audioOneOut),
    .audOe(audioOneOe),
    .audIn(audioOneIn),
    .gpOut(gpMidOut),
    .gpOe(gpMidOe),
    .gpIn(gpMidIn),
    .padOut(port1PadOut),
    .padOe(port1PadOe),
    .padIn(port1PadIn)
  );

  epsm_addr_mux u_addr (
    .pinSel(addrSel_q),
    .emAddrOut(emAddrOut),
    .emAddrOe(emAddrOe),
    .gpOut(gpHighOut),
    .gpOe(gpHighOe),
    .gpIn(gpHighIn),
    .padOut(addrPadOut),
    .padOe(addrPadOe),
    .padIn(addrPadIn)
  );

  // ********************************************************
  // Assertions
  // ********************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  property p_sp1_field;
    wrHit |=> second_serial_port_mode_q == $past(ioWrData[11:10]);
  endproperty
  a_sp1_field: assert property (p_sp1_field) else $error("second port mode not stored");

  property p_sp1_audio;
    second_serial_port_mode_q == 2'h1 |-> port1PadOut == {gpMidOut[5:4], audioOneOut}
      && port1PadOe == {gpMidOe[5:4], audioOneOe};
  endproperty
  a_sp1_audio: assert property (p_sp1_audio) else $error("second port audio route wrong");

  property p_sp1_gpio;
    second_serial_port_mode_q == 2'h2 |-> port1PadOut == gpMidOut && port1PadOe == gpMidOe
      && gpMidIn == port1PadIn;
  endproperty
  a_sp1_gpio: assert property (p_sp1_gpio) else $error("second port gpio route wrong");

  property p_sp1_card;
    second_serial_port_mode_q == 2'h0 |-> port1PadOut == cardOneOut && port1PadOe == cardOneOe
      && cardOneIn == port1PadIn;
  endproperty
  a_sp1_card: assert property (p_sp1_card) else $error("second port card route wrong");

  property p_sp0_field;
    wrHit |=> first_serial_port_mode_q == $past(ioWrData[9:8]);
  endproperty
  a_sp0_field: assert property (p_sp0_field) else $error("first port mode not stored");

  property p_sp0_card;
    first_serial_port_mode_q == 2'h0 |-> port0PadOut == cardZeroOut && port0PadOe == cardZeroOe
      && cardZeroIn == port0PadIn;
  endproperty
  a_sp0_card: assert property (p_sp0_card) else $error("first port card route wrong");

  property p_sp0_audio;
    first_serial_port_mode_q == 2'h1 |-> port0PadOut == {gpLowOut[5:4], audioZeroOut}
      && audioZeroIn == port0PadIn[3:0];
  endproperty
  a_sp0_audio: assert property (p_sp0_audio) else $error("first port audio route wrong");

  property p_sp0_gpio;
    first_serial_port_mode_q == 2'h2 |-> port0PadOut == gpLowOut && port0PadOe == gpLowOe;
  endproperty
  a_sp0_gpio: assert property (p_sp0_gpio) else $error("first port gpio route wrong");

  property p_resv_read;
    rdStrobe ##1 1'b1 |-> ioRdData[15] == 1'b0 && ioRdData[7:6] == 2'h0;
  endproperty
  a_resv_read: assert property (p_resv_read) else $error("reserved bits read nonzero");

  property p_readback;
    rdStrobe && addrHit && !wrHit |=> ioRdData == $past(selImage);
  endproperty
  a_readback: assert property (p_readback) else $error("read data mismatch");

  property p_addr20;
    addrSel_q[5] |-> addrPadOut[5] == gpHighOut[5] && addrPadOe[5] == gpHighOe[5];
  endproperty
  a_addr20: assert property (p_addr20) else $error("address pin 20 gpio route wrong");

  property p_addr15;
    !addrSel_q[0] |-> addrPadOut[0] == emAddrOut[0] && gpHighIn[0] == 1'b0;
  endproperty
  a_addr15: assert property (p_addr15) else $error("address pin 15 route wrong");

  property p_addr19;
    addrPadOut[4] == (addrSel_q[4] ? gpHighOut[4] : emAddrOut[4])
      && addrPadOe[4] == (addrSel_q[4] ? gpHighOe[4] : emAddrOe[4]);
  endproperty
  a_addr19: assert property (p_addr19) else $error("address pin 19 route wrong");

  property p_addr18;
    addrPadOut[3] == (addrSel_q[3] ? gpHighOut[3] : emAddrOut[3])
      && addrPadOe[3] == (addrSel_q[3] ? gpHighOe[3] : emAddrOe[3]);
  endproperty
  a_addr18: assert property (p_addr18) else $error("address pin 18 route wrong");

  property p_addr17;
    addrPadOut[2] == (addrSel_q[2] ? gpHighOut[2] : emAddrOut[2])
      && addrPadOe[2] == (addrSel_q[2] ? gpHighOe[2] : emAddrOe[2]);
  endproperty
  a_addr17: assert property (p_addr17) else $error("address pin 17 route wrong");

  property p_addr16;
    addrPadOut[1] == (addrSel_q[1] ? gpHighOut[1] : emAddrOut[1])
      && addrPadOe[1] == (addrSel_q[1] ? gpHighOe[1] : emAddrOe[1]);
  endproperty
  a_addr16: assert property (p_addr16) else $error("address pin 16 route wrong");

  property p_apply_next;
    wrHit && ioWrData[9:8] == 2'h2 ##1 first_serial_port_mode_q == 2'h2 |-> port0PadOut == gpLowOut;
  endproperty
  a_apply_next: assert property (p_apply_next) else $error("routing not applied");

  property p_hold;
    !wrHit |=> $stable(first_serial_port_mode_q) && $stable(second_serial_port_mode_q) && $stable(addrSel_q);
  endproperty
  a_hold: assert property (p_hold) else $error("register changed without write");

  property p_pp_field;
    wrHit |=> parallelPortMode == $past(ioWrData[14:12]);
  endproperty
  a_pp_field: assert property (p_pp_field) else $error("parallel mode not stored");

  property p_resv_code;
    first_serial_port_mode_q == 2'h3 |-> port0PadOe == 6'h00;
  endproperty
  a_resv_code: assert property (p_resv_code) else $error("reserved code drives pins");

  property p_sp1_resv;
    second_serial_port_mode_q == 2'h3 |-> port1PadOe == 6'h00 && gpMidIn == 6'h00;
  endproperty
  a_sp1_resv: assert property (p_sp1_resv) else $error("reserved code drives port 1");

  property p_ce_freeze;
    !ce |=> $stable(first_serial_port_mode_q) && $stable(second_serial_port_mode_q) && $stable(addrSel_q) && $stable(ioRdData);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while enable low");

  property p_reset_clear;
    disable iff (1'b0)
    // Looked at one edge on: fields are unknown until the first edge in reset
    !arst_n |=> first_serial_port_mode_q == 2'h0 && second_serial_port_mode_q == 2'h0 && addrSel_q == 6'h00;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset value wrong");

  c_sp0_gpio: cover property (wrHit ##1 first_serial_port_mode_q == 2'h2);
  c_sp1_audio: cover property (wrHit ##1 second_serial_port_mode_q == 2'h1);
  c_addr_all_gpio: cover property (addrSel_q == 6'h3F);
  c_pp_mode: cover property (rdStrobe && addrHit && parallel_port_mode_q != 3'h0);
  c_sp0_audio: cover property (wrHit ##1 first_serial_port_mode_q == 2'h1);

endmodule // epsm_pin_select

// *** rtl/epsm_serial_mux.sv ***
`timescale 1ns/100ps
module epsm_serial_mux
  import epsm_pkg::*;
(
  input wire logic [1:0] modeSel,
  input wire logic [5:0] cardOut,
  input wire logic [5:0] cardOe,
  output logic [5:0] cardIn,
  input wire logic [3:0] audOut,
  input wire logic [3:0] audOe,
  output logic [3:0] audIn,
  input wire logic [5:0] gpOut,
  input wire logic [5:0] gpOe,
  output logic [5:0] gpIn,
  output logic [5:0] padOut,
  output logic [5:0] padOe,
  input wire logic [5:0] padIn
);

  wire selCard = (modeSel == EPSM_SP_MODE_CARD);
  wire selAud = (modeSel == EPSM_SP_MODE_AUDIO);
  wire selGpio = (modeSel == EPSM_SP_MODE_GPIO);

  // ********************************************************
  // Per-pin routing; pins 5:4 carry general-purpose lines in audio mode
  // ********************************************************
  genvar i;
  generate
    for (i = 0; i < EPSM_SP_PINS; i++) begin : g_pin
      wire audPin = selAud && (i < EPSM_AUD_PINS);
      wire gpPin = selGpio || (selAud && (i >= EPSM_AUD_PINS));
      wire audO = (i < EPSM_AUD_PINS) ? audOut[i % EPSM_AUD_PINS] : 1'b0;
      wire audE = (i < EPSM_AUD_PINS) ? audOe[i % EPSM_AUD_PINS] : 1'b0;
      // Reserved code leaves the pin undriven so no function fights the pad
      assign padOut[i] = selCard ? cardOut[i] : audPin ? audO : gpPin ? gpOut[i] : 1'b0;
      assign padOe[i] = selCard ? cardOe[i] : audPin ? audE : gpPin ? gpOe[i] : 1'b0;
      assign cardIn[i] = selCard & padIn[i];
      assign gpIn[i] = gpPin & padIn[i];
    end
    for (i = 0; i < EPSM_AUD_PINS; i++) begin : g_aud
      assign audIn[i] = selAud & padIn[i];
    end
  endgenerate

endmodule // epsm_serial_mux
